/* dhp_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dhp_map.svh"
// programming port: serial and parallel access to buffer registers
module dhp_port
#(
  parameter int NBYTES = `DHP_NUM_BYTES
)
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // serial port pins
  input wire logic serClk,
  input wire logic serSelN,
  input wire logic serDataIn,
  output logic serDataOut,
  output logic serDataOe,
  // parallel port pins
  input wire logic parClk,
  input wire logic parSelN,
  input wire logic parRead,
  input wire logic [7:0] parBusIn,
  output logic [7:0] parBusOut,
  output logic parBusOe,
  // update strobe and sync clock
  input wire logic ioUpdate,
  input wire logic syncClk,
  // register layout: byte count of each register, base byte of each
  input wire logic [2:0] regLen [`DHP_NUM_REGS],
  input wire logic [5:0] regBase [`DHP_NUM_REGS],
  // status
  output logic lsbFirst,
  output logic updated
);
  //////////////////////////////////////////////////////////////////
  // synchronised pins
  logic sckRise, sckFall, csn;
  logic pckRise, pcs, prw;
  logic upd, synRise;
  logic [7:0] pBusM, pBus; // parallel bus sync chain
  dhp_edge_sync uSck (.clock(clock), .nrst(nrst), .pinIn(serClk), .level(),
    .rise(sckRise), .fall(sckFall));
  // selects idle high: their chains reset high so reset never looks like a select
  dhp_edge_sync #(.INIT(1'b1)) uCs (.clock(clock), .nrst(nrst), .pinIn(serSelN),
    .level(csn), .rise(), .fall());
  dhp_edge_sync uPck (.clock(clock), .nrst(nrst), .pinIn(parClk), .level(),
    .rise(pckRise), .fall());
  dhp_edge_sync #(.INIT(1'b1)) uPcs (.clock(clock), .nrst(nrst), .pinIn(parSelN),
    .level(pcs), .rise(), .fall());
  dhp_edge_sync uPrw (.clock(clock), .nrst(nrst), .pinIn(parRead), .level(prw),
    .rise(), .fall());
  dhp_edge_sync uUpd (.clock(clock), .nrst(nrst), .pinIn(ioUpdate), .level(upd),
    .rise(), .fall());
  dhp_edge_sync uSyn (.clock(clock), .nrst(nrst), .pinIn(syncClk), .level(),
    .rise(synRise), .fall());
  // bus needs only two stages; sampled at the parallel edge after settling
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pBusM <= 8'h00;
      pBus <= 8'h00;
    end
    else
    begin
      pBusM <= parBusIn;
      pBus <= pBusM;
    end
  end
  // the serial data bit travels with the clock through a matched delay
  logic sdM, sd;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sdM <= 1'b0;
      sd <= 1'b0;
    end
    else
    begin
      sdM <= serDataIn;
      sd <= sdM;
    end
  end
  //////////////////////////////////////////////////////////////////
  // register storage: buffer and active copies, byte addressed
  logic [7:0] bufReg [NBYTES];
  logic [7:0] actReg [NBYTES];
  //////////////////////////////////////////////////////////////////
  // serial controller
  dhp_pkg::dhp_ser_t serPhase;
  logic [2:0] bitCnt; // bits taken in the current byte
  logic [7:0] shiftIn; // incoming byte shifter
  logic [7:0] shiftOut; // outgoing byte shifter
  logic serRd; // read cycle
  logic [4:0] serAddr; // register addressed
  logic [2:0] byteLeft; // bytes remaining after current
  logic [5:0] byteAddr; // current byte address
  logic walkUp; // byte walk direction, fixed when the instruction decodes
  // serial bits only count while selected; deselect freezes all state
  wire serEdge = sckRise & ~csn;
  wire serOut = sckFall & ~csn;
  wire byteDone = serEdge & (bitCnt == `DHP_INS_BITS);
  // assemble in selected order: msb first shifts left, lsb first right
  wire [7:0] nextShift = lsbFirst ? {sd, shiftIn[7:1]} : {shiftIn[6:0], sd};
  wire [4:0] insAddr = nextShift[`DHP_INS_ADDR_MSB:0];
  wire [2:0] insLen = regLen[insAddr];
  // msb first starts at top byte and walks down, lsb first walks up
  wire [5:0] firstByte = lsbFirst ? regBase[insAddr] :
    6'(regBase[insAddr] + 6'(insLen) - 6'h01);
  // a mid-cycle order change flips bit order only; the walk stays inside the register
  wire [5:0] stepByte = walkUp ? 6'(byteAddr + 6'h01) : 6'(byteAddr - 6'h01);
  wire serWr = (serPhase == dhp_pkg::DHP_SER_DATA) & ~serRd & byteDone;
  // order bit takes effect as soon as its byte lands
  wire [7:0] serWrByte = nextShift;
  wire lsbHit = serWr & (byteAddr == `DHP_LSBF_BYTE);
  // serial state machine
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      serPhase <= dhp_pkg::DHP_SER_INS;
      bitCnt <= 3'h0;
      shiftIn <= 8'h00;
      serRd <= 1'b0;
      serAddr <= 5'h00;
      byteLeft <= 3'h0;
      byteAddr <= 6'h00;
      walkUp <= 1'b0;
    end
    else if (serEdge)
    begin
      bitCnt <= 3'(bitCnt + 3'h1);
      shiftIn <= nextShift;
      if (byteDone)
      begin
        case (serPhase)
          dhp_pkg::DHP_SER_INS:
          begin
            // instruction complete: decode direction and address
            serRd <= nextShift[`DHP_INS_READ_BIT];
            serAddr <= insAddr;
            byteAddr <= firstByte;
            walkUp <= lsbFirst;
            byteLeft <= 3'(insLen - 3'h1);
            serPhase <= dhp_pkg::DHP_SER_DATA;
          end
          dhp_pkg::DHP_SER_DATA:
          begin
            if (byteLeft == 3'h0)
              serPhase <= dhp_pkg::DHP_SER_INS;
            else
            begin
              byteLeft <= 3'(byteLeft - 3'h1);
              byteAddr <= stepByte;
            end
          end
          default: serPhase <= dhp_pkg::DHP_SER_INS;
        endcase
      end
    end
  end
  //////////////////////////////////////////////////////////////////
  // serial read output: load at byte start, shift on falling edges
  wire [5:0] loadAddr = (serPhase == dhp_pkg::DHP_SER_INS) ? firstByte : stepByte;
  wire loadOut = byteDone & ((serPhase == dhp_pkg::DHP_SER_INS) ? nextShift[7] :
    (serRd & byteLeft != 3'h0));
  logic pendLoad; // a fresh byte waits for the next falling edge
  logic [7:0] loadVal;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      shiftOut <= 8'h00;
      pendLoad <= 1'b0;
      loadVal <= 8'h00;
      serDataOut <= 1'b0;
      serDataOe <= 1'b0;
    end
    else
    begin
      if (loadOut)
      begin
        pendLoad <= 1'b1;
        loadVal <= bufReg[loadAddr];
      end
      else if (serOut)
      begin
        // driven on the falling edge
        pendLoad <= 1'b0;
        serDataOut <= pendLoad ? (lsbFirst ? loadVal[0] : loadVal[7]) :
          (lsbFirst ? shiftOut[1] : shiftOut[6]);
        shiftOut <= pendLoad ? loadVal :
          (lsbFirst ? {1'b0, shiftOut[7:1]} : {shiftOut[6:0], 1'b0});
      end
      // shared pin released when deselected or not in read data
      serDataOe <= ~csn & serRd & (serPhase == dhp_pkg::DHP_SER_DATA);
    end
  end
  //////////////////////////////////////////////////////////////////
  // parallel port: address, data, reinit
  dhp_pkg::dhp_par_t parState;
  logic [5:0] parAddr;
  logic parIsRd;
  wire parWr = (parState == dhp_pkg::DHP_PAR_DATA) & pckRise & ~parIsRd & ~pcs;
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      parState <= dhp_pkg::DHP_PAR_IDLE;
      parAddr <= 6'h00;
      parIsRd <= 1'b0;
      parBusOut <= 8'h00;
      parBusOe <= 1'b0;
    end
    else if (pcs)
    begin
      // select high aborts any access
      parState <= dhp_pkg::DHP_PAR_IDLE;
      parBusOe <= 1'b0;
    end
    else if (pckRise)
    begin
      case (parState)
        dhp_pkg::DHP_PAR_IDLE:
        begin
          parAddr <= pBus[5:0];
          parIsRd <= prw;
          parState <= dhp_pkg::DHP_PAR_DATA;
        end
        dhp_pkg::DHP_PAR_DATA:
        begin
          // read byte appears after the second edge
          parBusOut <= bufReg[parAddr];
          parBusOe <= parIsRd;
          parState <= dhp_pkg::DHP_PAR_REINIT;
        end
        dhp_pkg::DHP_PAR_REINIT:
        begin
          parBusOe <= 1'b0;
          parState <= dhp_pkg::DHP_PAR_IDLE;
        end
        default: parState <= dhp_pkg::DHP_PAR_IDLE;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////
  // update strobe sampled on sync clock rising edges
  wire doUpdate = synRise & upd;
  genvar gi;
  generate
    for (gi = 0; gi < NBYTES; gi++)
    begin : gByte
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
        begin
          bufReg[gi] <= 8'h00;
          actReg[gi] <= 8'h00;
        end
        else
        begin
          if (serWr & (byteAddr == 6'(gi)))
            bufReg[gi] <= serWrByte;
          else if (parWr & (parAddr == 6'(gi)))
            bufReg[gi] <= pBus;
          if (doUpdate)
            actReg[gi] <= bufReg[gi];
        end
      end
    end
  endgenerate
  // order bit is live from the buffer so it acts mid-cycle
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      lsbFirst <= 1'b0;
      updated <= 1'b0;
    end
    else
    begin
      if (lsbHit)
        lsbFirst <= serWrByte[`DHP_LSBF_BIT];
      else if (parWr & (parAddr == `DHP_LSBF_BYTE))
        lsbFirst <= pBus[`DHP_LSBF_BIT];
      updated <= doUpdate;
    end
  end
  //////////////////////////////////////////////////////////////////
  // checks
  a_rst_phase: assert property (@(posedge clock) $rose(nrst) |->
    serPhase == dhp_pkg::DHP_SER_INS) else $error("bad reset phase");
  a_ins_to_data: assert property (@(posedge clock) disable iff (!nrst)
    (serPhase == dhp_pkg::DHP_SER_INS && byteDone) |=> serPhase == dhp_pkg::DHP_SER_DATA)
    else $error("instruction not followed by data");
  a_read_dir: assert property (@(posedge clock) disable iff (!nrst)
    (serPhase == dhp_pkg::DHP_SER_INS && byteDone) |=> serRd == $past(nextShift[7]))
    else $error("direction wrong");
  a_hold_desel: assert property (@(posedge clock) disable iff (!nrst)
    csn |=> $stable(bitCnt)) else $error("counted while deselected");
  a_pin_release: assert property (@(posedge clock) disable iff (!nrst)
    csn[*2] |-> !serDataOe) else $error("pin driven while deselected");
  a_par_abort: assert property (@(posedge clock) disable iff (!nrst)
    pcs |=> parState == dhp_pkg::DHP_PAR_IDLE) else $error("parallel not reset");
  a_par_read: assert property (@(posedge clock) disable iff (!nrst)
    (parState == dhp_pkg::DHP_PAR_DATA && pckRise && !pcs && parIsRd) |=> parBusOe)
    else $error("read byte not driven");
  a_par_seq: assert property (@(posedge clock) disable iff (!nrst)
    (parState == dhp_pkg::DHP_PAR_DATA && pckRise && !pcs) |=>
    parState == dhp_pkg::DHP_PAR_REINIT) else $error("sequence broken");
  a_update_copy: assert property (@(posedge clock) disable iff (!nrst)
    doUpdate |=> updated) else $error("update not flagged");
  a_active_copy: assert property (@(posedge clock) disable iff (!nrst)
    doUpdate |=> actReg[`DHP_LSBF_BYTE] == $past(bufReg[`DHP_LSBF_BYTE]))
    else $error("active copy missed");
  c_ser_read: cover property (@(posedge clock) serDataOe);
  c_par_write: cover property (@(posedge clock) parWr);
  c_lsb_mode: cover property (@(posedge clock) lsbFirst);
endmodule : dhp_port
`default_nettype wire

/* dhp_map.svh */
// How it works
// - first eight serial edges form instruction byte
// - instruction bit 7 one means read
// - bits 4..0 address register, 6..5 ignored
// - serial transfers move every byte of register
// - after last byte, next eight edges instruct
// - sample on rising edge, drive on falling
// - one shared bidirectional serial data pin
// - select high: pin released, cycle suspended
// - lsb first bit 23 picks order, default msb
// - msb mode walks bytes down, lsb walks up
// - order change applies right after its byte
// - parallel select high resets parallel port
// - direction high with select low means read
// - shared 8-bit bus carries address and data
// - parallel access takes three parallel clocks
// - read byte driven after second parallel edge
// - writes fill buffers; update strobe copies to active
// - update strobe sampled by synchronisation clock
`ifndef DHP_MAP_SVH
`define DHP_MAP_SVH
// byte-addressed register space
`define DHP_NUM_BYTES 64
`define DHP_NUM_REGS 32
// instruction byte fields
`define DHP_INS_READ_BIT 7
`define DHP_INS_ADDR_MSB 4
// lsb first control: byte 2 of the first control register, bit 7
`define DHP_LSBF_BYTE 6'h02
`define DHP_LSBF_BIT 7
`define DHP_INS_BITS 3'h7
`endif

/* dhp_pkg.sv */
package dhp_pkg;
  // serial controller phases, gray along instruction -> data
  typedef enum logic [1:0] {DHP_SER_INS = 2'b00, DHP_SER_DATA = 2'b01} dhp_ser_t;
  // parallel port states, gray along idle -> data -> reinit
  typedef enum logic [1:0] {
    DHP_PAR_IDLE = 2'b00,
    DHP_PAR_DATA = 2'b01,
    DHP_PAR_REINIT = 2'b11
  } dhp_par_t;
endpackage : dhp_pkg

/* dhp_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser with rising and falling edge pulses
module dhp_edge_sync
#(
  // reset level; set to the pin's idle level so no false edge follows reset
  parameter logic INIT = 1'b0
)
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // asynchronous level in
  input wire logic pinIn,
  // synchronised level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta; // first stage, read only by the second
  logic last; // previous synchronised value
  //////////////////////////////////////////////////////////////////
  // sync chain; edges come from second and third stages only
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      meta <= INIT;
      level <= INIT;
      last <= INIT;
    end
    else
    begin
      meta <= pinIn;
      level <= meta;
      last <= level;
    end
  end
  assign rise = level & ~last;
  assign fall = ~level & last;
endmodule : dhp_edge_sync
`default_nettype wire

/* dhp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// system controller model driving both programming ports
module dhp_host_model
(
  // pacing clock
  input wire logic clock,
  // serial pins
  output logic serClk,
  output logic serSelN,
  output logic serDataIn,
  input wire logic serDataOut,
  input wire logic serDataOe,
  // parallel pins
  output logic parClk,
  output logic parSelN,
  output logic parRead,
  output logic [7:0] parBusIn,
  input wire logic [7:0] parBusOut,
  input wire logic parBusOe
);
  logic hostBit; // host level on the shared data wire
  // device drive wins; a released wire toggles so a stale bit never matches
  assign serDataIn = serDataOe ? serDataOut : hostBit;
  // idle: clock low, both ports deselected
  initial
  begin
    {serClk, serSelN, hostBit, parClk, parSelN, parRead} = 6'h12;
    parBusIn = 8'h00;
  end
  ////////////////////////////////////////////////////////////
  // one byte on the serial pin; susp pulses the clock while deselected
  task automatic serByte(input logic drv, input logic lsbf, input logic [7:0] d,
    input int susp, output logic [7:0] q);
    int idx;
    for (int i = 0; i < 8; i++)
    begin
      idx = lsbf ? i : 7 - i;
      hostBit = drv ? d[idx] : ~hostBit;
      if (i == susp)
      begin
        // deselect well after the last counted fall and reselect well after
        // the last ignored one, so no edge straddles the select change
        #40 serSelN = 1'b1; // these edges must not count
        repeat (3)
        begin
          #62.5 serClk = 1'b1;
          #62.5 serClk = 1'b0;
        end
        #40 serSelN = 1'b0;
      end
      // sample just before the rise, device drove after the fall
      #62.5 q[idx] = serDataIn;
      serClk = 1'b1;
      #62.5 serClk = 1'b0;
    end
  endtask : serByte
  // three-clock parallel access, optionally dropped after the address clock
  task automatic parAcc(input logic rd, input logic [7:0] a, input logic [7:0] d,
    input logic abort, output logic [7:0] q, output logic oe);
    @(negedge clock);
    parSelN = 1'b0;
    parRead = rd;
    parBusIn = a;
    repeat (8) @(negedge clock);
    parClk = 1'b1; // address clock
    repeat (8) @(negedge clock);
    parClk = 1'b0;
    parBusIn = rd ? ~a : d; // released bus shows a changed pattern
    parSelN = abort;
    repeat (8) @(negedge clock);
    parClk = 1'b1;
    repeat (8) @(negedge clock);
    q = parBusOut;
    oe = parBusOe;
    parClk = 1'b0;
    repeat (8) @(negedge clock);
    parClk = 1'b1; // re-initialisation clock
    repeat (8) @(negedge clock);
    parClk = 1'b0;
    parSelN = 1'b1;
  endtask : parAcc
endmodule : dhp_host_model
`default_nettype wire

/* dhp_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// bench: host model drives the port, a byte model predicts every read
module dhp_port_bench;
  logic clock, nrst, syncClk, ioUpdate, serClk, serSelN, serDataIn, serDataOut, serDataOe;
  logic parClk, parSelN, parRead, parBusOe, lsbFirst, updated;
  logic [7:0] parBusIn, parBusOut;
  logic [2:0] lenTab [32]; // byte count per register
  logic [5:0] baseTab [32]; // first byte per register
  logic [7:0] mem [64]; // predicted buffer bytes
  logic [7:0] wq [$]; // forced write bytes, random when empty
  logic lsbM = 1'b0; // predicted bit order
  int seed = 32'h76e6;
  int miscompares = 0;
  int nTests = 0;
  int updCount = 0; // copy pulses seen
  int cyc = 0;
  dhp_port DUT (.clock(clock), .nrst(nrst), .serClk(serClk), .serSelN(serSelN),
    .serDataIn(serDataIn), .serDataOut(serDataOut), .serDataOe(serDataOe), .parClk(parClk),
    .parSelN(parSelN), .parRead(parRead), .parBusIn(parBusIn), .parBusOut(parBusOut),
    .parBusOe(parBusOe), .ioUpdate(ioUpdate), .syncClk(syncClk), .regLen(lenTab),
    .regBase(baseTab), .lsbFirst(lsbFirst), .updated(updated));
  dhp_host_model host (.clock(clock), .serClk(serClk), .serSelN(serSelN),
    .serDataIn(serDataIn), .serDataOut(serDataOut), .serDataOe(serDataOe), .parClk(parClk),
    .parSelN(parSelN), .parRead(parRead), .parBusIn(parBusIn), .parBusOut(parBusOut),
    .parBusOe(parBusOe));
  ////////////////////////////////////////////////////////////
  // clocks; sync clock runs at a quarter of the system clock rate, its edges on system clock falls
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    syncClk = 1'b0;
    forever #20 syncClk = ~syncClk;
  end
  // copy pulse counter and hang guard
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (updated === 1'b1)
      updCount <= updCount + 1;
    if (cyc == 40000)
    begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one whole-register serial cycle; byte walk fixed at start, bit order live
  task automatic serCycle(input logic rd, input int r, input int susp);
    logic [7:0] got, d;
    logic up;
    int b;
    up = lsbM;
    host.serByte(1'b1, lsbM, {rd, 2'($random(seed)), 5'(r)}, susp, got);
    for (int k = 0; k < int'(lenTab[r]); k++)
    begin
      b = up ? baseTab[r] + k : baseTab[r] + lenTab[r] - 1 - k;
      d = (rd || wq.size() == 0) ? 8'($random(seed)) : wq.pop_front();
      host.serByte(!rd, lsbM, d, k == 0 ? susp : -1, got);
      if (rd)
        check("serial read", got, mem[b]);
      else
        mem[b] = d;
      if (!rd && b == 2)
      begin
        lsbM = d[7];
        #20 check("bit order", {7'h0, lsbFirst}, {7'h0, lsbM});
      end
    end
  endtask : serCycle
  // single-byte parallel access against the byte model
  task automatic parCycle(input logic rd, input int a, input logic abort);
    logic [7:0] d, q;
    logic oe;
    d = 8'($random(seed));
    host.parAcc(rd, 8'(a), d, abort, q, oe);
    if (rd)
    begin
      check("parallel enable", {7'h0, oe}, 8'h01);
      check("parallel read", q, mem[a]);
    end
    else if (!abort)
      mem[a] = d;
  endtask : parCycle
  ////////////////////////////////////////////////////////////
  initial
  begin
    int a;
    int u;
    nrst = 1'b0;
    ioUpdate = 1'b0;
    // layout: four, two and six byte registers, the rest single bytes
    for (int i = 0; i < 32; i++)
    begin
      lenTab[i] = 3'h1;
      baseTab[i] = 6'(i + 9);
    end
    {lenTab[0], lenTab[1], lenTab[2]} = {3'h4, 3'h2, 3'h6};
    {baseTab[0], baseTab[1], baseTab[2]} = {6'h00, 6'h04, 6'h06};
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    check("reset state", {6'h0, lsbFirst, updated}, 8'h00);
    host.serSelN = 1'b0; // select held low between cycles
    // pass 0 in msb order ends by switching to lsb; pass 1 switches back
    for (int m = 0; m < 2; m++)
    begin
      serCycle(1'b0, 1, m == 0 ? 3 : -1);
      serCycle(1'b0, 2, -1);
      serCycle(1'b0, 5, -1);
      serCycle(1'b1, 1, -1);
      serCycle(1'b1, 2, 5);
      serCycle(1'b1, 5, -1);
      // palindromic bytes after the order byte read the same either way
      if (m == 0)
        wq = {8'($random(seed)), 8'h80, 8'h81, 8'h3c};
      else
        wq = {8'h81, 8'h3c, 8'h00, 8'h18};
      serCycle(1'b0, 0, -1);
      serCycle(1'b1, 0, -1);
    end
    check("no early copy", 8'(updCount), 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      a = 12 + ($random(seed) & 15);
      parCycle(1'b0, a, 1'b0);
      parCycle(1'b1, a, 1'b0);
    end
    parCycle(1'b0, a, 1'b1);
    parCycle(1'b1, a, 1'b0);
    parCycle(1'b1, 7, 1'b0);
    // one strobe after many writes, longer than a sync period
    ioUpdate = 1'b1;
    repeat (10) @(negedge clock);
    ioUpdate = 1'b0;
    repeat (10) @(negedge clock);
    check("copy seen", 8'(updCount != 0), 8'h01);
    u = updCount;
    repeat (30) @(negedge clock);
    check("no idle copy", 8'(updCount - u), 8'h00);
    close_out();
  end
endmodule : dhp_port_bench
`default_nettype wire
